// file: rtl/cec_regs.svh
// offsets, field positions, reset values and codes of the if-then unit
`ifndef CEC_REGS_SVH
`define CEC_REGS_SVH

`define CEC_ADDR_W 8
`define CEC_DATA_W 32

`define CEC_OFF_STATE 8'h00
`define CEC_OFF_STATUS 8'h04

`define CEC_STATE_RST 8'h00
`define CEC_STATUS_INSIDE 0
`define CEC_STATUS_FINAL 1
`define CEC_STATUS_BPASS 2

`define CEC_COND_AL 4'hE
`define CEC_COND_NV 4'hF
`define CEC_LAST_SLOT 4'h8

`define CEC_BASE_EQ 3'h0
`define CEC_BASE_CS 3'h1
`define CEC_BASE_MI 3'h2
`define CEC_BASE_VS 3'h3
`define CEC_BASE_HI 3'h4
`define CEC_BASE_GE 3'h5
`define CEC_BASE_GT 3'h6
`define CEC_BASE_AL 3'h7

`define CEC_RESP_OKAY 2'h0
`define CEC_RESP_SLVERR 2'h2

`endif

// file: rtl/cec_pkg.sv
// types shared by the if-then unit and its condition evaluator
package cec_pkg;

  typedef logic [7:0] cec_state_t;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } cec_flags_s;

  typedef struct packed {
    logic valid;
    logic done;
    logic isItInst;
    logic [3:0] itFirstCond;
    logic [3:0] itMask;
    logic isCondBranch;
    logic [3:0] branchCond;
    logic isUndefined;
    logic branchTaken;
  } cec_inst_s;

endpackage

// file: rtl/cec_cond_eval.sv
// four-bit condition against the n, z, c, v flags
`include "cec_regs.svh"

module cec_cond_eval
  import cec_pkg::*;
(
  // condition and flags
  input wire logic [3:0] condSel,
  input wire cec_flags_s flags,
  // outcome
  output logic passOut
);

  logic baseTest;

  always_comb begin
    case (condSel[3:1])
      `CEC_BASE_EQ: baseTest = flags.z;
      `CEC_BASE_CS: baseTest = flags.c;
      `CEC_BASE_MI: baseTest = flags.n;
      `CEC_BASE_VS: baseTest = flags.v;
      `CEC_BASE_HI: baseTest = flags.c && !flags.z;
      `CEC_BASE_GE: baseTest = (flags.n == flags.v);
      `CEC_BASE_GT: baseTest = (flags.n == flags.v) && !flags.z;
      `CEC_BASE_AL: baseTest = 1'b1;
      default: baseTest = 1'b1;
    endcase
  end

  // 1111 is not inverted, so it also executes always
  assign passOut = (condSel[0] && (condSel != `CEC_COND_NV)) ? !baseTest : baseTest;

endmodule

// file: rtl/cec_if_then_unit.sv
// if-then state holder, condition selection and check, AXI4-Lite register slave
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`include "cec_regs.svh"

module cec_if_then_unit
  import cec_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // pipeline side
  input wire cec_inst_s instIn,
  input wire cec_flags_s appStatusFlags,
  output logic [3:0] activeConditionSelect,
  output logic conditionCheckResult,
  output logic undefAsNop,
  output logic undefException,
  output logic insideBlockFlag,
  output logic finalBlockSlotFlag,
  output cec_state_t ifThenState,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`CEC_ADDR_W-1:0] s_axi_awaddr,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [`CEC_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [`CEC_ADDR_W-1:0] s_axi_araddr,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [`CEC_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  cec_state_t ifThenState_r;
  cec_state_t ifThenState_nxt;
  cec_state_t blockStateStep;
  cec_state_t itLoadVal;
  logic blockPass;
  logic completes;
  logic alwaysBranch;
  logic swStateWrite;

  logic awHeld_r;
  logic [`CEC_ADDR_W-1:0] awAddr_r;
  logic wHeld_r;
  logic [`CEC_DATA_W-1:0] wData_r;
  logic [3:0] wStrb_r;
  logic bValid_r;
  logic [1:0] bResp_r;
  logic rValid_r;
  logic [`CEC_DATA_W-1:0] rData_r;
  logic [1:0] rResp_r;
  logic doWrite;
  logic [`CEC_ADDR_W-1:0] wrWord;
  logic [`CEC_ADDR_W-1:0] rdWord;

  ////////////////////////////////////////////////////////////////////////////
  // condition selection and evaluation

  assign activeConditionSelect = instIn.isCondBranch ? instIn.branchCond : ifThenState_r[7:4];

  cec_cond_eval u_active_eval (
    .condSel(activeConditionSelect),
    .flags(appStatusFlags),
    .passOut(conditionCheckResult)
  );

  // block condition alone, needed when a branch carries its own field
  cec_cond_eval u_block_eval (
    .condSel(ifThenState_r[7:4]),
    .flags(appStatusFlags),
    .passOut(blockPass)
  );

  assign alwaysBranch = instIn.isCondBranch && (instIn.branchCond == `CEC_COND_AL);

  // a failed block check turns both cases into a silent nop
  assign undefException = instIn.valid &&
    ((instIn.isUndefined && conditionCheckResult) ||
     (alwaysBranch && !(insideBlockFlag && !blockPass)));

  assign undefAsNop = instIn.valid &&
    ((instIn.isUndefined && !conditionCheckResult) ||
     (alwaysBranch && insideBlockFlag && !blockPass));

  ////////////////////////////////////////////////////////////////////////////
  // if-then state

  assign insideBlockFlag = (ifThenState_r[3:0] != 4'h0);
  assign finalBlockSlotFlag = (ifThenState_r[3:0] == `CEC_LAST_SLOT);
  assign ifThenState = ifThenState_r;

  assign completes = instIn.valid && instIn.done;
  assign itLoadVal = {instIn.itFirstCond, instIn.itMask};

  // last slot has bits 2 to 0 clear, so stepping out leaves all zero
  assign blockStateStep = (ifThenState_r[2:0] == 3'h0) ? `CEC_STATE_RST :
    {ifThenState_r[7:5], ifThenState_r[3:0], 1'b0};

  always_comb begin
    ifThenState_nxt = ifThenState_r;
    if (completes && instIn.isItInst) begin
      ifThenState_nxt = itLoadVal;
    end else if (completes && instIn.branchTaken) begin
      ifThenState_nxt = `CEC_STATE_RST;
    end else if (completes && insideBlockFlag) begin
      ifThenState_nxt = blockStateStep;
    end else if (swStateWrite) begin
      // pipeline updates win; a debugger write during a load, a taken branch or an in-block step is lost
      ifThenState_nxt = wData_r[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ifThenState_r <= `CEC_STATE_RST;
    end else begin
      ifThenState_r <= ifThenState_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write path

  assign s_axi_awready = !awHeld_r && !bValid_r;
  assign s_axi_wready = !wHeld_r && !bValid_r;
  assign doWrite = awHeld_r && wHeld_r && !bValid_r;
  assign wrWord = {awAddr_r[`CEC_ADDR_W-1:2], 2'b00};
  assign swStateWrite = doWrite && (wrWord == `CEC_OFF_STATE) && wStrb_r[0];
  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      awHeld_r <= 1'b0;
      awAddr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_r <= 1'b1;
      awAddr_r <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wHeld_r <= 1'b0;
      wData_r <= '0;
      wStrb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_r <= 1'b1;
      wData_r <= s_axi_wdata;
      wStrb_r <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bValid_r <= 1'b0;
      bResp_r <= `CEC_RESP_OKAY;
    end else if (doWrite) begin
      bValid_r <= 1'b1;
      // status is read-only: writes there are ignored but accepted
      bResp_r <= ((wrWord == `CEC_OFF_STATE) || (wrWord == `CEC_OFF_STATUS)) ?
        `CEC_RESP_OKAY : `CEC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bValid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read path

  assign s_axi_arready = !rValid_r;
  assign rdWord = {s_axi_araddr[`CEC_ADDR_W-1:2], 2'b00};
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rValid_r <= 1'b0;
      rData_r <= '0;
      rResp_r <= `CEC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rValid_r <= 1'b1;
      rResp_r <= `CEC_RESP_OKAY;
      rData_r <= '0;
      if (rdWord == `CEC_OFF_STATE) begin
        rData_r[7:0] <= ifThenState_r;
      end else if (rdWord == `CEC_OFF_STATUS) begin
        rData_r[`CEC_STATUS_INSIDE] <= insideBlockFlag;
        rData_r[`CEC_STATUS_FINAL] <= finalBlockSlotFlag;
        rData_r[`CEC_STATUS_BPASS] <= blockPass;
      end else begin
        rResp_r <= `CEC_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rValid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  branch_cond_sel_a: assert property (
    instIn.isCondBranch |-> activeConditionSelect == instIn.branchCond)
    else $error("branch condition not taken from the branch field");

  block_cond_sel_a: assert property (
    !instIn.isCondBranch |-> activeConditionSelect == ifThenState_r[7:4])
    else $error("condition not taken from if-then state");

  not_equal_a: assert property (
    activeConditionSelect == 4'h1 |-> conditionCheckResult == !appStatusFlags.z)
    else $error("inverted zero test wrong");

  higher_test_a: assert property (
    activeConditionSelect == 4'h8 |->
      conditionCheckResult == (appStatusFlags.c && !appStatusFlags.z))
    else $error("carry and not zero test wrong");

  greater_test_a: assert property (
    activeConditionSelect == 4'hC |->
      conditionCheckResult == ((appStatusFlags.n == appStatusFlags.v) && !appStatusFlags.z))
    else $error("greater-than test wrong");

  always_pass_a: assert property (
    activeConditionSelect[3:1] == `CEC_BASE_AL |-> conditionCheckResult)
    else $error("always condition failed");

  reset_clear_a: assert property (
    $past(rst) |-> ifThenState_r == `CEC_STATE_RST && !insideBlockFlag)
    else $error("state not cleared by reset");

  state_load_a: assert property (
    completes && instIn.isItInst |=> ifThenState_r == $past(itLoadVal))
    else $error("if-then instruction did not load state");

  step_shift_a: assert property (
    completes && !instIn.isItInst && !instIn.branchTaken && insideBlockFlag &&
      ifThenState_r[2:0] != 3'h0
    |=> ifThenState_r[4:0] == {$past(ifThenState_r[3:0]), 1'b0} && $stable(ifThenState_r[7:5]))
    else $error("state did not shift on step");

  step_clear_a: assert property (
    completes && !instIn.isItInst && finalBlockSlotFlag |=> ifThenState_r == `CEC_STATE_RST)
    else $error("last slot did not return to normal execution");

  branch_exit_a: assert property (
    completes && !instIn.isItInst && instIn.branchTaken |=> !insideBlockFlag ##0 ifThenState_r == 8'h00)
    else $error("branch completion left block active");

  undef_nop_a: assert property (
    instIn.valid && instIn.isUndefined && !conditionCheckResult && !alwaysBranch
    |-> undefAsNop && !undefException)
    else $error("failed undefined instruction raised exception");

  always_branch_a: assert property (
    instIn.valid && alwaysBranch && !insideBlockFlag |-> undefException)
    else $error("always-branch outside block not undefined");

  final_inside_a: assert property (
    finalBlockSlotFlag |-> insideBlockFlag && ifThenState_r[2:0] == 3'h0)
    else $error("last slot flag without block");

endmodule

// file: tb/cec_pipe_model.sv
// pipeline stage model that hands instructions to the if-then unit
module cec_pipe_model
  import cec_pkg::*;
(
  // instruction toward the unit
  output cec_inst_s instIn
);
  timeunit 1ns;
  timeprecision 1ns;
  initial instIn = '0;
  // called just after a rising edge; the value stands until the next call
  task automatic drive(input cec_inst_s inst);
    // loads only carry entry masks; a branch completion is issued on purpose
    instIn <= inst;
  endtask
endmodule

// file: tb/cec_if_then_unit_tb.sv
// self-checking bench of the if-then unit
`include "cec_regs.svh"
module cec_if_then_unit_tb
  import cec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // {cond, n z c v, expected pass}
  localparam logic [8:0] ROWS [16] = '{9'h009, 9'h028, 9'h045, 9'h061, 9'h091, 9'h0B0, 9'h0C0, 9'h0E2,
    9'h10C, 9'h124, 9'h153, 9'h171, 9'h188, 9'h1A0, 9'h1C1, 9'h1FF};
  localparam logic [7:0] SEQ [4] = '{8'hAB, 8'hB6, 8'hAC, 8'hB8};
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  cec_inst_s instIn;
  cec_flags_s appStatusFlags = '0;
  logic [3:0] activeConditionSelect;
  logic conditionCheckResult, undefAsNop, undefException, insideBlockFlag, finalBlockSlotFlag;
  cec_state_t ifThenState;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int bad_count = 0;
  int n_tests = 0;
  logic [31:0] q;
  logic [1:0] r;

  always #5 sys_clk = ~sys_clk;

  cec_pipe_model i_cec_pipe_model (.instIn);
  cec_if_then_unit i_cec_if_then_unit (.sys_clk, .rst, .instIn, .appStatusFlags, .activeConditionSelect,
    .conditionCheckResult, .undefAsNop, .undefException, .insideBlockFlag, .finalBlockSlotFlag, .ifThenState,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);

  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // flags and instruction land together; comb outputs are settled 1 ns later
  task automatic put(input logic [3:0] f, input cec_inst_s inst);
    @(posedge sys_clk);
    appStatusFlags <= f;
    i_cec_pipe_model.drive(inst);
    #1;
  endtask

  // ready is sampled mid-cycle, where it cannot move before the next edge
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
    output logic [1:0] rs);
    int k;
    logic fin, ta, tw;
    fin = 1'b0;
    @(posedge sys_clk);
    if (wr) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    for (k = 0; k < 40 && !fin; k++) begin
      @(negedge sys_clk);
      ta = wr ? s_axi_awready : s_axi_arready;
      tw = wr && s_axi_wready;
      fin = wr ? s_axi_bvalid : s_axi_rvalid;
      rd = s_axi_rdata;
      rs = wr ? s_axi_bresp : s_axi_rresp;
      @(posedge sys_clk);
      if (ta) begin
        s_axi_awvalid <= 1'b0;
        s_axi_arvalid <= 1'b0;
      end
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    if (!fin) begin
      bad_count++;
      stop_test();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    chk("state", 8'h00, ifThenState);
    foreach (ROWS[i]) begin
      put(ROWS[i][4:1], cec_inst_s'{1, 0, 0, 0, 0, 1, ROWS[i][8:5], 0, 0});
      chk("select", ROWS[i][8:5], activeConditionSelect);
      chk("pass", ROWS[i][0], conditionCheckResult);
      chk("exception", ROWS[i][8:5] == 4'hE, undefException);
    end
    // four-slot block, slots alternate failing and passing under n set, v clear
    put(4'h8, cec_inst_s'{1, 1, 1, 4'hA, 4'hB, 0, 0, 0, 0});
    for (int s = 0; s < 4; s++) begin
      put(4'h8, cec_inst_s'{1, 0, 0, 0, 0, 0, 0, 1, 0});
      chk("state", SEQ[s], ifThenState);
      chk("select", SEQ[s][7:4], activeConditionSelect);
      chk("pass", s[0], conditionCheckResult);
      chk("nop", !s[0], undefAsNop);
      chk("exception", s[0], undefException);
      chk("slot", {s == 3, 1'b1}, {finalBlockSlotFlag, insideBlockFlag});
      put(4'h8, cec_inst_s'{1, 1, 0, 0, 0, 0, 0, 0, 0});
    end
    put(4'h0, '0);
    chk("state", 9'h000, {insideBlockFlag, ifThenState});
    // always-branch under a failing block, then a branch ends the block early
    put(4'h0, cec_inst_s'{1, 1, 1, 4'h0, 4'hF, 0, 0, 0, 0});
    put(4'h0, cec_inst_s'{1, 0, 0, 0, 0, 1, 4'hE, 0, 0});
    chk("exception", 1'b0, undefException);
    chk("nop", 1'b1, undefAsNop);
    put(4'h0, cec_inst_s'{1, 1, 0, 0, 0, 0, 0, 0, 1});
    put(4'h0, '0);
    chk("state", 8'h00, ifThenState);
    axi(1'b1, `CEC_OFF_STATE, 32'h0000_0038, q, r);
    chk("bresp", `CEC_RESP_OKAY, r);
    axi(1'b0, `CEC_OFF_STATE, 32'h0, q, r);
    chk("state", 32'h0000_0038, q);
    axi(1'b0, `CEC_OFF_STATUS, 32'h0, q, r);
    chk("status", 32'h0000_0007, q);
    axi(1'b1, 8'h08, 32'h0000_00FF, q, r);
    chk("bresp", `CEC_RESP_SLVERR, r);
    axi(1'b0, 8'h08, 32'h0, q, r);
    chk("rdata", 32'h0, q);
    chk("rresp", `CEC_RESP_SLVERR, r);
    // byte lane 0 off, then the read-only status word: both answered, neither moves the state
    s_axi_wstrb <= 4'hE;
    axi(1'b1, `CEC_OFF_STATE, 32'h0000_0011, q, r);
    chk("bresp", `CEC_RESP_OKAY, r);
    s_axi_wstrb <= 4'hF;
    axi(1'b1, `CEC_OFF_STATUS, 32'h0000_0011, q, r);
    chk("bresp", `CEC_RESP_OKAY, r);
    chk("state", 8'h38, ifThenState);
    @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    chk("state", 8'h00, ifThenState);
    stop_test();
  end
endmodule
